// file: verilog/tx_cfg_device.sv
`timescale 1ns/1ps
`default_nettype none
module tx_cfg_device
	import tx_cfg_pkg::*;
(
	input  wire logic       CLK_SYS,        // system clock
	input  wire logic       SRST,           // sync reset
	tx_cfg_if.device        BUS,            // register port
	input  wire logic       E1_MODE,        // e1 when high
	input  wire logic       T1E1_CONV,      // rate conversion active
	input  wire logic [7:0] PTR_SEP_BYTES,  // store pointer separation
	input  wire logic       TX_BIT_STB,     // transmit bit strobe
	input  wire logic       TX_BIT_ONE,     // transmit bit is a one
	input  wire logic       FRAME_PULSE,    // frame boundary pulse
	input  wire logic       MF_PULSE,       // multiframe boundary pulse
	input  wire logic       SIG_FRAME,      // current frame is signaling
	input  wire logic       TCLK_PIN,       // transmit clock pin
	input  wire logic       FSYNC_PIN_I,    // frame sync pin input
	input  wire logic       SSYNC_PIN_I,    // system sync pin input
	input  wire logic       SSYNC_IS_INPUT, // system sync pin is input
	output logic            FSYNC_PIN_O,    // frame sync pin output
	output logic            FSYNC_PIN_OE,   // frame sync pin enable
	output logic            TCLK_INT,       // clock after inversion
	output logic            FSYNC_INT,      // frame sync after inversion
	output logic            SSYNC_INT,      // system sync after inversion
	output logic            MF_PASS_FWD,    // pass-forward reference
	output logic            MF_FREE_RUN,    // line counters free run
	output logic            SSYNC_MF_MODE,  // system sync multiframe
	output logic            SYSCLK_FAST,    // system clock rate mode
	output logic            FRAME_D4,       // d4 framing
	output logic            LOOP_CODE_EN,   // loop code active
	output logic [4:0]      LOOP_CODE_LEN,  // loop code length
	output logic            CRC_RECALC,     // crc recalc active
	output logic            BPV_INSERT,     // insert violation, pulse
	output logic            DATA_56K,       // 56k channel format
	output logic            GAPPED_CLK,     // gapped channel clock
	output logic            STORE_BYPASS,   // store bypassed
	output logic [9:0]      STORE_DEPTH,    // store depth in bits
	output logic            STORE_ALIGN,    // align pointers, pulse
	output logic            STORE_PTR_RST,  // reset read pointer, pulse
	output logic            FORCE_SLIP,     // controlled slip, level while in zone
	output logic            MW_ALAW,        // milliwatt a-law
	output logic            INV_FRAMING,    // invert framing bits
	output logic            INV_SIGNALING,  // invert signaling bits
	output logic            INV_PAYLOAD,    // invert payload bits
	output logic            JAM_BIT8,       // force bit 8
	output logic            JAM_BIT7,       // force bit 7 in sig frames
	output logic            RAI_CI,         // rai-ci pattern
	output logic            AIS_CI,         // ais-ci pattern
	output logic [5:0]      FIFO_LOW_WM,    // fifo watermark bytes
	output logic            FRAME_INTERLEAVE // frame interleave bus
);
	import tx_cfg_pkg::*;
	// ****************************************************************
	// register file
	// ****************************************************************
	logic [7:0] misc_r, io_r, store_r, code_r, hdlc_r, ibus_r; // registers
	logic [7:0] rdata_r;   // read data
	logic       rvalid_r;  // read valid
	logic [7:0] rmux;      // read select
	logic       hit_misc, hit_io, hit_store, hit_code, hit_hdlc, hit_ibus;
	assign hit_misc  = BUS.addr == ADDR_MISC;
	assign hit_io    = BUS.addr == ADDR_IO;
	assign hit_store = BUS.addr == ADDR_STORE;
	assign hit_code  = BUS.addr == ADDR_CODE;
	assign hit_hdlc  = BUS.addr == ADDR_HDLC;
	assign hit_ibus  = BUS.addr == ADDR_IBUS;
	assign rmux = hit_misc ? misc_r : hit_io ? io_r : hit_store ? store_r :
		hit_code ? code_r : hit_hdlc ? hdlc_r : hit_ibus ? ibus_r : READ_NONE;
	// writes and reads
	always_ff @(posedge CLK_SYS)
	begin
		if (SRST)
		begin
			misc_r <= REG_RESET;
			io_r <= REG_RESET;
			store_r <= REG_RESET;
			code_r <= REG_RESET;
			hdlc_r <= REG_RESET;
			ibus_r <= REG_RESET;
			rdata_r <= READ_NONE;
			rvalid_r <= 1'b0;
		end
		else
		begin
			if (BUS.wr && hit_misc) misc_r <= BUS.wdata & MASK_MISC;
			if (BUS.wr && hit_io) io_r <= BUS.wdata;
			if (BUS.wr && hit_store) store_r <= BUS.wdata & MASK_STORE;
			if (BUS.wr && hit_code) code_r <= BUS.wdata;
			if (BUS.wr && hit_hdlc) hdlc_r <= BUS.wdata & MASK_HDLC;
			if (BUS.wr && hit_ibus) ibus_r <= BUS.wdata & MASK_IBUS;
			rdata_r <= BUS.rd ? rmux : READ_NONE;
			rvalid_r <= BUS.rd;
		end
	end
	assign BUS.rdata = rdata_r;
	assign BUS.rvalid = rvalid_r;
	// ****************************************************************
	// command edges and violation insertion
	// ****************************************************************
	logic viol_q_r, algn_q_r, srst_q_r; // previous command bits
	logic armed_r;                      // violation waiting for ones
	logic [1:0] ones_r;                 // consecutive ones count
	logic viol_rise, algn_rise, srst_rise, ones_done;
	assign viol_rise = misc_r[B_VIOL] & ~viol_q_r;
	assign algn_rise = store_r[B_SALGN] & ~algn_q_r;
	assign srst_rise = store_r[B_SRST] & ~srst_q_r;
	assign ones_done = TX_BIT_STB & TX_BIT_ONE & (ones_r == ONES_RUN - 2'd1);
	// edge memory, arming and ones run
	always_ff @(posedge CLK_SYS)
	begin
		if (SRST)
		begin
			viol_q_r <= 1'b0;
			algn_q_r <= 1'b0;
			srst_q_r <= 1'b0;
			armed_r <= 1'b0;
			ones_r <= 2'd0;
		end
		else
		begin
			viol_q_r <= misc_r[B_VIOL];
			algn_q_r <= store_r[B_SALGN];
			srst_q_r <= store_r[B_SRST];
			// new arming wins over the firing that ends an old one
			armed_r <= viol_rise | (armed_r & ~ones_done);
			if (TX_BIT_STB)
				ones_r <= ~TX_BIT_ONE ? 2'd0 : ones_done ? 2'd0 : ones_r + 2'd1;
		end
	end
	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	logic [2:0] pin_s1_r, pin_s2_r; // clock, frame sync, system sync
	always_ff @(posedge CLK_SYS)
	begin
		if (SRST)
		begin
			pin_s1_r <= 3'd0;
			pin_s2_r <= 3'd0;
		end
		else
		begin
			pin_s1_r <= {SSYNC_PIN_I, FSYNC_PIN_I, TCLK_PIN};
			pin_s2_r <= pin_s1_r;
		end
	end
	// ****************************************************************
	// decoded control
	// ****************************************************************
	logic t1;           // t1 operation
	logic dw_hold_r;    // second half of a double wide pulse
	logic fs_src, fs_nxt, dw_nxt;
	logic [7:0] half_frame, slip_zone;
	logic [5:0] wm_nxt;
	logic [4:0] len_nxt;
	assign t1 = ~E1_MODE;
	// pulse source by mode, stretched in t1 signaling frames when double wide is set
	assign fs_src = io_r[B_FSM] ? MF_PULSE : FRAME_PULSE;
	assign dw_nxt = t1 & io_r[B_FSDW] & SIG_FRAME & fs_src;
	assign fs_nxt = (fs_src | dw_hold_r) ^ io_r[B_FSINV];
	assign half_frame = E1_MODE ? HALF_E1 : HALF_T1;
	assign slip_zone = store_r[B_SZS] ? SLIP_NARROW : SLIP_WIDE;
	assign wm_nxt = hdlc_r[1:0] == 2'b00 ? WM_00 : hdlc_r[1:0] == 2'b01 ? WM_01 :
		hdlc_r[1:0] == 2'b10 ? WM_10 : WM_11;
	assign len_nxt = code_r[1:0] == 2'b00 ? LEN_00 : code_r[1:0] == 2'b01 ? LEN_01 :
		code_r[1:0] == 2'b10 ? LEN_10 : LEN_11;
	// pins and reference
	always_ff @(posedge CLK_SYS)
	begin
		if (SRST)
		begin
			dw_hold_r <= 1'b0;
			FSYNC_PIN_O <= 1'b0;
			FSYNC_PIN_OE <= 1'b0;
			TCLK_INT <= 1'b0;
			FSYNC_INT <= 1'b0;
			SSYNC_INT <= 1'b0;
			MF_PASS_FWD <= 1'b0;
			MF_FREE_RUN <= 1'b0;
			SSYNC_MF_MODE <= 1'b0;
			SYSCLK_FAST <= 1'b0;
		end
		else
		begin
			dw_hold_r <= dw_nxt;
			FSYNC_PIN_O <= fs_nxt;
			FSYNC_PIN_OE <= io_r[B_FSDIR];
			TCLK_INT <= pin_s2_r[0] ^ io_r[B_CLKINV];
			FSYNC_INT <= pin_s2_r[1] ^ io_r[B_FSINV];
			SSYNC_INT <= pin_s2_r[2] ^ (io_r[B_SSINV] & SSYNC_IS_INPUT);
			MF_PASS_FWD <= misc_r[B_MULTIFRAME_REF_SELECT];
			MF_FREE_RUN <= ~misc_r[B_MULTIFRAME_REF_SELECT] & io_r[B_FSDIR];
			SSYNC_MF_MODE <= io_r[B_SSM];
			SYSCLK_FAST <= io_r[B_SCLKM];
		end
	end
	// formatter and store control
	always_ff @(posedge CLK_SYS)
	begin
		if (SRST)
		begin
			FRAME_D4 <= 1'b0;
			LOOP_CODE_EN <= 1'b0;
			LOOP_CODE_LEN <= LEN_00;
			CRC_RECALC <= 1'b0;
			BPV_INSERT <= 1'b0;
			DATA_56K <= 1'b0;
			GAPPED_CLK <= 1'b0;
			STORE_BYPASS <= 1'b1;
			STORE_DEPTH <= DEPTH_T1;
			STORE_ALIGN <= 1'b0;
			STORE_PTR_RST <= 1'b0;
			FORCE_SLIP <= 1'b0;
		end
		else
		begin
			FRAME_D4 <= t1 & misc_r[B_TFM];
			LOOP_CODE_EN <= t1 & misc_r[B_LOOP_CRC];
			LOOP_CODE_LEN <= len_nxt;
			CRC_RECALC <= E1_MODE & misc_r[B_LOOP_CRC];
			BPV_INSERT <= armed_r & ones_done;
			DATA_56K <= store_r[B_FMT56];
			GAPPED_CLK <= store_r[B_GCLK];
			STORE_BYPASS <= ~store_r[B_SEN];
			STORE_DEPTH <= store_r[B_SMDM] ? DEPTH_MIN : E1_MODE ? DEPTH_E1 : DEPTH_T1;
			STORE_ALIGN <= algn_rise & (PTR_SEP_BYTES < half_frame);
			STORE_PTR_RST <= srst_rise;
			FORCE_SLIP <= store_r[B_SEN] & T1E1_CONV & (PTR_SEP_BYTES <= slip_zone);
		end
	end
	// code, alarm, fifo and bus options
	always_ff @(posedge CLK_SYS)
	begin
		if (SRST)
		begin
			MW_ALAW <= 1'b0;
			INV_FRAMING <= 1'b0;
			INV_SIGNALING <= 1'b0;
			INV_PAYLOAD <= 1'b0;
			JAM_BIT8 <= 1'b0;
			JAM_BIT7 <= 1'b0;
			RAI_CI <= 1'b0;
			AIS_CI <= 1'b0;
			FIFO_LOW_WM <= WM_00;
			FRAME_INTERLEAVE <= 1'b0;
		end
		else
		begin
			MW_ALAW <= code_r[B_LAW];
			INV_FRAMING <= code_r[6:5] == 2'b01;
			INV_SIGNALING <= code_r[6:5] == 2'b10;
			INV_PAYLOAD <= code_r[6:5] == 2'b11;
			JAM_BIT8 <= code_r[B_JBEN];
			JAM_BIT7 <= code_r[B_JBEN] & t1;
			RAI_CI <= t1 & ~misc_r[B_TFM] & code_r[B_REMOTE_ALARM_PATTERN_MODE];
			AIS_CI <= t1 & code_r[B_ALARM_INDICATION_PATTERN_MODE];
			FIFO_LOW_WM <= wm_nxt;
			FRAME_INTERLEAVE <= ibus_r[B_INTERLEAVE_TYPE_SELECT];
		end
	end
endmodule
`default_nettype wire

// file: verilog/tx_cfg_pkg.sv
`default_nettype none
package tx_cfg_pkg;
	// ****************************************************************
	// register offsets
	// ****************************************************************
	localparam logic [8:0] ADDR_MISC  = 9'h183; // frame misc control
	localparam logic [8:0] ADDR_IO    = 9'h184; // io config
	localparam logic [8:0] ADDR_STORE = 9'h185; // elastic store control
	localparam logic [8:0] ADDR_CODE  = 9'h186; // code and alarm control
	localparam logic [8:0] ADDR_HDLC  = 9'h187; // hdlc fifo control
	localparam logic [8:0] ADDR_IBUS  = 9'h188; // interleave bus control
	localparam logic [7:0] REG_RESET  = 8'h00;  // every register resets here
	localparam logic [7:0] READ_NONE  = 8'h00;  // unmapped read answer
	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int B_LOOP_CRC = 0; // misc: loop code (t1) / crc recalc (e1)
	localparam int B_VIOL     = 1; // misc: violation insert command
	localparam int B_TFM      = 2; // misc: d4 select
	localparam int B_MULTIFRAME_REF_SELECT     = 3; // misc: multiframe reference select
	localparam int B_FSM      = 0; // io: frame sync mode
	localparam int B_FSDW     = 1; // io: double wide
	localparam int B_FSDIR    = 2; // io: frame sync direction
	localparam int B_SSM      = 3; // io: system sync mode
	localparam int B_SCLKM    = 4; // io: system clock rate mode
	localparam int B_SSINV    = 5; // io: system sync invert
	localparam int B_FSINV    = 6; // io: frame sync invert
	localparam int B_CLKINV   = 7; // io: clock invert
	localparam int B_SEN      = 0; // store: enable
	localparam int B_SMDM     = 1; // store: min delay
	localparam int B_SRST     = 2; // store: pointer reset command
	localparam int B_SALGN    = 3; // store: align command
	localparam int B_SZS      = 4; // store: slip zone
	localparam int B_GCLK     = 6; // store: gapped clock
	localparam int B_FMT56    = 7; // store: 56k format
	localparam int B_ALARM_INDICATION_PATTERN_MODE    = 2; // code: ais-ci
	localparam int B_REMOTE_ALARM_PATTERN_MODE    = 3; // code: rai-ci
	localparam int B_JBEN     = 4; // code: jammed bit
	localparam int B_LAW      = 7; // code: a-law
	localparam int B_INTERLEAVE_TYPE_SELECT   = 4; // ibus: frame interleave
	localparam logic [7:0] MASK_MISC = 8'h0f; // writable bits
	localparam logic [7:0] MASK_STORE = 8'hdf;
	localparam logic [7:0] MASK_HDLC = 8'h03;
	localparam logic [7:0] MASK_IBUS = 8'h10;
	// ****************************************************************
	// decoded values
	// ****************************************************************
	localparam logic [5:0] WM_00 = 6'd4;  // fifo low watermark bytes
	localparam logic [5:0] WM_01 = 6'd16;
	localparam logic [5:0] WM_10 = 6'd32;
	localparam logic [5:0] WM_11 = 6'd48;
	localparam logic [4:0] LEN_00 = 5'd5; // loop code lengths (shortest first)
	localparam logic [4:0] LEN_01 = 5'd6;
	localparam logic [4:0] LEN_10 = 5'd7;
	localparam logic [4:0] LEN_11 = 5'd16;
	localparam logic [7:0] SLIP_WIDE = 8'd9;   // slip zone, clustered
	localparam logic [7:0] SLIP_NARROW = 8'd2; // slip zone, distributed
	localparam logic [7:0] HALF_T1 = 8'd12;    // half frame bytes, t1
	localparam logic [7:0] HALF_E1 = 8'd16;    // half frame bytes, e1
	localparam logic [9:0] DEPTH_T1 = 10'd386; // two frames of bits, t1
	localparam logic [9:0] DEPTH_E1 = 10'd512; // two frames of bits, e1
	localparam logic [9:0] DEPTH_MIN = 10'd32; // minimum delay depth
	localparam logic [1:0] ONES_RUN = 2'd3;    // ones before a violation
endpackage
`default_nettype wire

// file: verilog/tx_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tx_cfg_if;
	logic       wr;    // write strobe, one cycle, two back to back when a command bit is cleared
	logic       rd;    // read strobe, one cycle
	logic [8:0] addr;  // register offset
	logic [7:0] wdata; // write data
	logic [7:0] rdata; // read data
	logic       rvalid; // read data valid, one cycle
	modport device (input wr, input rd, input addr, input wdata, output rdata, output rvalid);
	modport host (output wr, output rd, output addr, output wdata, input rdata, input rvalid);
endinterface
`default_nettype wire

// file: verilog/tx_cfg_host.sv
`timescale 1ns/1ps
`default_nettype none
module tx_cfg_host
	import tx_cfg_pkg::*;
(
	input  wire logic       CLK_SYS,       // system clock
	input  wire logic       SRST,          // sync reset
	tx_cfg_if.host          BUS,           // register port
	input  wire logic       CMD_VALID,     // command request
	input  wire logic       CMD_WRITE,     // write when high
	input  wire logic [8:0] CMD_ADDR,      // register offset
	input  wire logic [7:0] CMD_WDATA,     // write data
	input  wire logic       SYSCLK_1544,   // system clock is 1.544
	input  wire logic       IBO_ENABLED,   // interleave bus enabled
	input  wire logic       SYNC_BACKPLANE, // backplane without slips
	input  wire logic       HW_SIG_INSERT, // hardware signaling wanted
	input  wire logic       SYSCLK_STABLE, // system clock present
	output logic            CMD_READY,     // idle, command accepted
	output logic            RSP_VALID,     // read answer, pulse
	output logic [7:0]      RSP_DATA       // read answer data
);
	import tx_cfg_pkg::*;
	typedef enum logic [1:0] {S_IDLE, S_CLEAR, S_READ} host_state_e;
	host_state_e state_r;
	logic       wr_r, rd_r;       // bus strobes
	logic [8:0] addr_r;           // bus address
	logic [7:0] wdata_r;          // bus data
	logic       store_en_r;       // shadow of store enable
	logic [7:0] fixed;            // write data after fixups
	logic [7:0] cleared;          // fixed data, commands dropped
	logic       take;             // command taken
	logic       has_cmd;          // fixed data carries a command bit
	logic [7:0] f_misc, f_io, f_store;
	assign take = CMD_VALID & CMD_READY;
	// pass-forward only with the store on
	assign f_misc = {CMD_WDATA[7:4], store_en_r & (HW_SIG_INSERT |
		(CMD_WDATA[B_MULTIFRAME_REF_SELECT] & SYNC_BACKPLANE)), CMD_WDATA[2:0]};
	// rate mode and double wide legality
	assign f_io = {CMD_WDATA[7:5], ~SYSCLK_1544 | IBO_ENABLED, CMD_WDATA[3:2],
		CMD_WDATA[B_FSDW] & ~CMD_WDATA[B_FSM] & CMD_WDATA[B_FSDIR],
		CMD_WDATA[0]};
	// commands dropped while the clock is not stable
	assign f_store = {CMD_WDATA[7:4], CMD_WDATA[3:2] & {2{SYSCLK_STABLE}},
		CMD_WDATA[1:0]};
	assign fixed = CMD_ADDR == ADDR_MISC ? f_misc : CMD_ADDR == ADDR_IO ? f_io :
		CMD_ADDR == ADDR_STORE ? f_store : CMD_WDATA;
	assign has_cmd = (CMD_ADDR == ADDR_MISC && fixed[B_VIOL]) ||
		(CMD_ADDR == ADDR_STORE && (fixed[B_SALGN] || fixed[B_SRST]));
	assign cleared = addr_r == ADDR_MISC ? wdata_r & ~(8'h01 << B_VIOL) :
		wdata_r & ~((8'h01 << B_SALGN) | (8'h01 << B_SRST));
	// command sequencer
	always_ff @(posedge CLK_SYS)
	begin
		if (SRST)
		begin
			state_r <= S_IDLE;
			wr_r <= 1'b0;
			rd_r <= 1'b0;
			addr_r <= 9'h000;
			wdata_r <= 8'h00;
			store_en_r <= 1'b0;
			CMD_READY <= 1'b0;
			RSP_VALID <= 1'b0;
			RSP_DATA <= 8'h00;
		end
		else
		begin
			wr_r <= 1'b0;
			rd_r <= 1'b0;
			RSP_VALID <= 1'b0;
			case (state_r)
				S_IDLE:
				begin
					CMD_READY <= 1'b1;
					if (take)
					begin
						CMD_READY <= 1'b0;
						addr_r <= CMD_ADDR;
						wdata_r <= fixed;
						wr_r <= CMD_WRITE;
						rd_r <= ~CMD_WRITE;
						if (CMD_WRITE && CMD_ADDR == ADDR_STORE)
							store_en_r <= fixed[B_SEN];
						// command bits fall again so the next one rises
						state_r <= ~CMD_WRITE ? S_READ : has_cmd ? S_CLEAR : S_IDLE;
					end
				end
				S_CLEAR:
				begin
					wr_r <= 1'b1;
					wdata_r <= cleared;
					state_r <= S_IDLE;
				end
				S_READ:
				begin
					if (BUS.rvalid)
					begin
						RSP_VALID <= 1'b1;
						RSP_DATA <= BUS.rdata;
						state_r <= S_IDLE;
					end
				end
				default:
					state_r <= S_IDLE;
			endcase
		end
	end
	assign BUS.wr = wr_r;
	assign BUS.rd = rd_r;
	assign BUS.addr = addr_r;
	assign BUS.wdata = wdata_r;
endmodule
`default_nettype wire

// file: test/tx_cfg_sva.sv
`timescale 1ns/1ps
`default_nettype none
module tx_cfg_sva
	import tx_cfg_pkg::*;
(
	input wire logic       CLK_SYS,
	input wire logic       SRST,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [8:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic       rvalid
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (SRST);
	property p_ans; rd |=> rvalid; endproperty
	a_ans: assert property (p_ans) else $error("read unanswered");
	property p_quiet; !rd |=> !rvalid; endproperty
	a_quiet: assert property (p_quiet) else $error("stray rvalid");
	property p_idle; !rvalid |-> rdata == READ_NONE; endproperty
	a_idle: assert property (p_idle) else $error("rdata not idle");
	property p_hdlc; rd && addr == ADDR_HDLC |=> rdata[7:2] == 6'h00; endproperty
	a_hdlc: assert property (p_hdlc) else $error("hdlc reserved set");
	property p_ibus; rd && addr == ADDR_IBUS |=> (rdata & ~MASK_IBUS) == 8'h00; endproperty
	a_ibus: assert property (p_ibus) else $error("ibus reserved set");
	property p_misc; rd && addr == ADDR_MISC |=> rdata[7:4] == 4'h0; endproperty
	a_misc: assert property (p_misc) else $error("misc reserved set");
	property p_unmap; rd && (addr < ADDR_MISC || addr > ADDR_IBUS) |=> rdata == READ_NONE; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read");
	property p_cmdclr; wr && addr == ADDR_STORE && wdata[3:2] != 2'b00
		|=> wr && addr == ADDR_STORE && wdata[3:2] == 2'b00; endproperty
	a_cmdclr: assert property (p_cmdclr) else $error("store cmd left set");
	property p_violclr; wr && addr == ADDR_MISC && wdata[1] |=> wr && !wdata[1]; endproperty
	a_violclr: assert property (p_violclr) else $error("violation bit left set");
endmodule
`default_nettype wire

// file: test/tx_framer_config_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tx_framer_config_bank_tb;
	import tx_cfg_pkg::*;
	logic clk = 1'b0, rst = 1'b1, cv = 1'b0, cw = 1'b0, e1 = 1'b0, stb = 1'b0, one = 1'b0;
	logic [8:0] ca = 9'h000;
	logic [7:0] cd = 8'h00, sep = 8'h00, rdat, q;
	logic s1544 = 1'b1, ibo = 1'b0, hws = 1'b0, stab = 1'b0, lo = 1'b0;
	logic rdy, rsp, oe, tci, fsi, pfw, fast, ssmf, d4, lpe, crc, bpv, byp, prst, alaw;
	logic invf, invs, invp, fi;
	logic conv = 1'b0, ssin = 1'b0, fp = 1'b0, sig = 1'b0, bpl = 1'b0;
	logic fso, ssi, frun, d56, gck, aln, slip, jb8, jb7, rai, ais;
	logic [4:0] len;
	logic [9:0] depth;
	logic [5:0] wm;
	int fail_count = 0, comparisons = 0, nbpv = 0, nrst = 0, naln = 0;
	logic [8:0] regs [6] = '{ADDR_MISC, ADDR_IO, ADDR_STORE, ADDR_CODE, ADDR_HDLC, ADDR_IBUS};
	logic [5:0] wms [4] = '{WM_00, WM_01, WM_10, WM_11};
	logic [4:0] lens [4] = '{LEN_00, LEN_01, LEN_10, LEN_11};
	tx_cfg_if bus();
	tx_cfg_host i_tx_cfg_host(.CLK_SYS(clk), .SRST(rst), .BUS(bus), .CMD_VALID(cv),
		.CMD_WRITE(cw), .CMD_ADDR(ca), .CMD_WDATA(cd), .SYSCLK_1544(s1544),
		.IBO_ENABLED(ibo), .SYNC_BACKPLANE(bpl), .HW_SIG_INSERT(hws), .SYSCLK_STABLE(stab),
		.CMD_READY(rdy), .RSP_VALID(rsp), .RSP_DATA(rdat));
	tx_cfg_device i_tx_cfg_device(.CLK_SYS(clk), .SRST(rst), .BUS(bus), .E1_MODE(e1),
		.T1E1_CONV(conv), .PTR_SEP_BYTES(sep), .TX_BIT_STB(stb), .TX_BIT_ONE(one),
		.FRAME_PULSE(fp), .MF_PULSE(lo), .SIG_FRAME(sig), .TCLK_PIN(lo), .FSYNC_PIN_I(lo),
		.SSYNC_PIN_I(lo), .SSYNC_IS_INPUT(ssin), .FSYNC_PIN_O(fso), .FSYNC_PIN_OE(oe),
		.TCLK_INT(tci), .FSYNC_INT(fsi), .SSYNC_INT(ssi), .MF_PASS_FWD(pfw),
		.MF_FREE_RUN(frun), .SSYNC_MF_MODE(ssmf), .SYSCLK_FAST(fast), .FRAME_D4(d4),
		.LOOP_CODE_EN(lpe), .LOOP_CODE_LEN(len), .CRC_RECALC(crc), .BPV_INSERT(bpv),
		.DATA_56K(d56), .GAPPED_CLK(gck), .STORE_BYPASS(byp), .STORE_DEPTH(depth),
		.STORE_ALIGN(aln), .STORE_PTR_RST(prst), .FORCE_SLIP(slip), .MW_ALAW(alaw),
		.INV_FRAMING(invf), .INV_SIGNALING(invs), .INV_PAYLOAD(invp), .JAM_BIT8(jb8),
		.JAM_BIT7(jb7), .RAI_CI(rai), .AIS_CI(ais), .FIFO_LOW_WM(wm),
		.FRAME_INTERLEAVE(fi));
	tx_cfg_sva i_tx_cfg_sva(.CLK_SYS(clk), .SRST(rst), .wr(bus.wr), .rd(bus.rd),
		.addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata), .rvalid(bus.rvalid));
	initial
	begin
		forever #2.5 clk = ~clk;
	end
	// count one-cycle pulses at the quiet edge
	always @(negedge clk)
	begin
		nbpv += bpv;
		nrst += prst;
		naln += aln;
	end
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e)
		begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	// one command on the host port, presented for one cycle once ready is seen
	task automatic cmd(input logic w, input logic [8:0] a, input logic [7:0] d);
		@(negedge clk);
		repeat (50) if (rdy !== 1'b1) @(negedge clk);
		cv = 1'b1;
		cw = w;
		ca = a;
		cd = d;
		@(negedge clk);
		cv = 1'b0;
		repeat (20) if (!w && rsp !== 1'b1) @(negedge clk);
		q = rdat;
		repeat (w ? 6 : 0) @(negedge clk);
	endtask
	task automatic rdchk(input logic [8:0] a, input logic [7:0] e);
		cmd(1'b0, a, 8'h00);
		chk("readback", e, q);
	endtask
	task automatic close_out();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (2) @(negedge clk);
		rst = 1'b0;
		repeat (2) @(negedge clk);
		foreach (regs[i]) rdchk(regs[i], REG_RESET);
		rdchk(9'h189, READ_NONE);
		chk("bypass", 1, byp);
		chk("depth", DEPTH_T1, depth);
		chk("fs_oe", 0, oe);
		$display("test reset done");
		for (int i = 0; i < 4; i++)
		begin
			cmd(1'b1, ADDR_HDLC, 8'hfc | 8'(i));
			rdchk(ADDR_HDLC, 8'(i));
			chk("watermark", wms[i], wm);
			cmd(1'b1, ADDR_CODE, {i[0], i[1:0], 3'b000, i[1:0]});
			chk("loop_len", lens[i], len);
			chk("invert", {i == 1, i == 2, i == 3}, {invf, invs, invp});
			chk("alaw", i[0], alaw);
		end
		cmd(1'b1, ADDR_CODE, 8'h1c);
		chk("jam_alarm", 4'hf, {jb8, jb7, rai, ais});
		$display("test codes done");
		cmd(1'b1, ADDR_IO, 8'hff);
		rdchk(ADDR_IO, 8'hed);
		chk("fast", 0, fast);
		chk("fs_oe_ssmf", 2'b11, {oe, ssmf});
		chk("inverted", 4'b1101, {tci, fsi, ssi, fso});
		chk("free_run", 1, frun);
		ssin = 1'b1;
		repeat (2) @(negedge clk);
		chk("ss_invert", 1, ssi);
		ibo = 1'b1;
		cmd(1'b1, ADDR_IO, 8'h06);
		rdchk(ADDR_IO, 8'h16);
		chk("fast", 1, fast);
		sig = 1'b1;
		@(negedge clk) fp = 1'b1;
		@(negedge clk) fp = 1'b0;
		chk("fs_first", 1, fso);
		@(negedge clk) chk("fs_wide", 1, fso);
		@(negedge clk) chk("fs_end", 0, fso);
		$display("test io done");
		cmd(1'b1, ADDR_STORE, 8'hff);
		rdchk(ADDR_STORE, 8'hd3);
		chk("bypass_depth", {1'b0, DEPTH_MIN}, {byp, depth});
		chk("fmt_gap", 2'b11, {d56, gck});
		conv = 1'b1;
		sep = SLIP_NARROW + 8'd1;
		repeat (2) @(negedge clk);
		chk("no_slip", 0, slip);
		sep = SLIP_NARROW;
		repeat (2) @(negedge clk);
		chk("slip", 1, slip);
		conv = 1'b0;
		sep = 8'h00;
		stab = 1'b1;
		cmd(1'b1, ADDR_STORE, 8'h05);
		rdchk(ADDR_STORE, 8'h01);
		chk("ptr_rst", 1, nrst);
		chk("depth", DEPTH_T1, depth);
		cmd(1'b1, ADDR_STORE, 8'h09);
		sep = HALF_T1;
		cmd(1'b1, ADDR_STORE, 8'h09);
		chk("align", 1, naln);
		sep = 8'h00;
		$display("test store done");
		cmd(1'b1, ADDR_MISC, 8'h08);
		rdchk(ADDR_MISC, 8'h00);
		bpl = 1'b1;
		cmd(1'b1, ADDR_MISC, 8'h08);
		rdchk(ADDR_MISC, 8'h08);
		bpl = 1'b0;
		hws = 1'b1;
		cmd(1'b1, ADDR_MISC, 8'hff);
		rdchk(ADDR_MISC, 8'h0d);
		chk("fwd_d4_loop", 4'b1110, {pfw, d4, lpe, frun});
		chk("rai_d4", 2'b01, {rai, ais});
		one = 1'b1;
		repeat (3)
		begin
			@(negedge clk) stb = 1'b1;
			@(negedge clk) stb = 1'b0;
		end
		repeat (3) @(negedge clk);
		chk("bpv", 1, nbpv);
		e1 = 1'b1;
		repeat (4) @(negedge clk);
		chk("crc_loop", 2'b10, {crc, lpe});
		chk("e1_jam_alarm", 4'b1000, {jb8, jb7, rai, ais});
		$display("test misc done");
		cmd(1'b1, ADDR_IBUS, 8'hff);
		rdchk(ADDR_IBUS, 8'h10);
		chk("interleave", 1, fi);
		cmd(1'b1, 9'h189, 8'hff);
		rdchk(9'h189, READ_NONE);
		$display("test ibus done");
		close_out();
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		fail_count++;
		close_out();
	end
endmodule
`default_nettype wire
